// file: dprwm_params.svh
// Constants for the dual-port RAM with write modes
`ifndef DPRWM_PARAMS_SVH
`define DPRWM_PARAMS_SVH

// Register byte offsets on the Wishbone slave
`define DPRWM_OFS_CTRL 4'h0
`define DPRWM_OFS_STATUS 4'h4
`define DPRWM_OFS_INFO 4'h8

// Control register fields
`define DPRWM_CTRL_MODE_A_LSB 0
`define DPRWM_CTRL_MODE_B_LSB 2

// Status register fields
`define DPRWM_STS_WW_BIT 0
`define DPRWM_STS_WR_BIT 1
`define DPRWM_STS_RANGE_BIT 2

// Reset values
`define DPRWM_CTRL_RST 4'h0
`define DPRWM_STS_RST 3'h0

// Read latency of each port in cycles
`define DPRWM_LATENCY 1

`endif

// file: dprwm_pkg.sv
// Types for the dual-port RAM with write modes
package dprwm_pkg;

  typedef enum logic [1:0] {
    DPRWM_RAW,
    DPRWM_RBW,
    DPRWM_NRW
  } dprwm_wmode_t;

  typedef enum logic [1:0] {
    DPRWM_DIST,
    DPRWM_BLOCK,
    DPRWM_LARGE
  } dprwm_kind_t;

endpackage

// file: dprwm_ram.sv
// Dual-port RAM with per-port write modes and a Wishbone control slave
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "dprwm_params.svh"

module dprwm_ram #(
  parameter dprwm_pkg::dprwm_kind_t MEM_KIND = dprwm_pkg::DPRWM_BLOCK,
  parameter int                     DEPTH_A  = 16,
  parameter int                     WIDTH_A  = 8,
  parameter int                     WIDTH_B  = 16,
  parameter int                     LATENCY  = `DPRWM_LATENCY,
  parameter bit                     HAS_EN_A = 1'b1,
  parameter bit                     HAS_EN_B = 1'b1,
  parameter bit                     HAS_RST_A = 1'b1,
  parameter bit                     HAS_RST_B = 1'b1,
  parameter int                     INIT_LEN = 1,
  parameter logic [INIT_LEN-1:0][31:0] INIT_VEC = '0,
  parameter int                     INIT_OUT_A = 0,
  parameter int                     INIT_OUT_B = 0,
  // Port B geometry follows from port A and the width ratio
  // derived depth
  localparam int                    FF       = WIDTH_B / WIDTH_A,
  localparam int                    DEPTH_B  = DEPTH_A / FF,
  localparam int                    AW_A     = $clog2(DEPTH_A),
  localparam int                    AW_B     = (DEPTH_B > 1) ? $clog2(DEPTH_B) : 1
) (
  input  wire logic               SYS_CLK,
  input  wire logic               SYS_RST,
  input  wire logic               A_EN,
  input  wire logic               A_RST,
  input  wire logic [AW_A-1:0]    A_ADDR,
  input  wire logic               A_WE,
  input  wire logic [WIDTH_A-1:0] A_WDATA,
  output wire logic [WIDTH_A-1:0] A_RDATA,
  output wire logic               A_INVALID,
  input  wire logic               B_EN,
  input  wire logic               B_RST,
  input  wire logic [AW_B-1:0]    B_ADDR,
  input  wire logic               B_WE,
  input  wire logic [WIDTH_B-1:0] B_WDATA,
  output wire logic [WIDTH_B-1:0] B_RDATA,
  output wire logic               B_INVALID,
  input  wire logic               WB_CYC,
  input  wire logic               WB_STB,
  input  wire logic               WB_WE,
  input  wire logic [3:0]         WB_ADR,
  input  wire logic [3:0]         WB_SEL,
  input  wire logic [31:0]        WB_DAT_I,
  output wire logic [31:0]        WB_DAT_O,
  output wire logic               WB_ACK
);
  import dprwm_pkg::*;

  // Refuse geometries the datapath cannot serve
  if (WIDTH_A < 1 || WIDTH_A > 31 || WIDTH_B < 1 || WIDTH_B > 31) begin : g_chk_w
    $error("Port widths must lie in 1..31");
  end
  if (WIDTH_B % WIDTH_A != 0 || DEPTH_A < 2 || DEPTH_A % FF != 0) begin : g_chk_ff
    $error("Port B width must be a whole multiple of port A width");
  end
  // reset port needs a registered output
  // enable port needs a registered output
  if (LATENCY != 1) begin : g_chk_lat
    $error("Only a read latency of one cycle is built");
  end
  if (INIT_LEN < 1) begin : g_chk_init
    $error("INIT_LEN must be at least one");
  end

  typedef logic [DEPTH_A-1:0][WIDTH_A-1:0] dprwm_mem_t;

  typedef struct packed {
    dprwm_mem_t         mem;
    logic [WIDTH_A-1:0] qa;
    logic [WIDTH_B-1:0] qb;
    logic               inva;
    logic               invb;
    dprwm_wmode_t       mode_a;
    dprwm_wmode_t       mode_b;
    logic [2:0]         sts;
    logic               ack;
    logic [31:0]        rdat;
  } dprwm_state_t;

  // Clamp an integer to the unsigned range of a port word
  function automatic logic [31:0] dprwm_sat(input int v, input int w);
    logic [31:0] top;
    top = (32'h1 << w) - 32'h1;
    if (v < 0) begin
      return 32'h0;
    end
    if (32'(v) > top) begin
      return top;
    end
    return 32'(v);
  endfunction

  function automatic dprwm_mem_t dprwm_init_mem();
    logic [31:0] s;
    dprwm_init_mem = '0;
    for (int i = 0; i < DEPTH_A; i++) begin
      if (MEM_KIND != DPRWM_LARGE && i < INIT_LEN) begin
        s = dprwm_sat($signed(INIT_VEC[i]), WIDTH_A);
        dprwm_init_mem[i] = s[WIDTH_A-1:0];
      end
    end
  endfunction

  // Assemble a port B word from consecutive port A words
  function automatic logic [WIDTH_B-1:0] dprwm_rd_b(input dprwm_mem_t m,
                                                    input logic [AW_B-1:0] a);
    dprwm_rd_b = '0;
    for (int k = 0; k < FF; k++) begin
      dprwm_rd_b[k*WIDTH_A +: WIDTH_A] = m[int'(a) * FF + k];
    end
  endfunction

  // modes apply to block memory only
  function automatic dprwm_wmode_t dprwm_eff(input dprwm_wmode_t m);
    if (MEM_KIND == DPRWM_BLOCK) begin
      return m;
    end
    return DPRWM_RBW;
  endfunction

  // Code 3 is not a mode; it falls back to read after write
  function automatic dprwm_wmode_t dprwm_legal(input logic [1:0] c);
    if (c == 2'h1) begin
      return DPRWM_RBW;
    end
    if (c == 2'h2) begin
      return DPRWM_NRW;
    end
    return DPRWM_RAW;
  endfunction

  localparam logic [31:0] OUT_A_INIT = dprwm_sat(INIT_OUT_A, WIDTH_A);
  localparam logic [31:0] OUT_B_INIT = dprwm_sat(INIT_OUT_B, WIDTH_B);

  localparam dprwm_state_t RST_STATE = '{
    mem:    dprwm_init_mem(),
    qa:     OUT_A_INIT[WIDTH_A-1:0],
    qb:     OUT_B_INIT[WIDTH_B-1:0],
    inva:   1'b0,
    invb:   1'b0,
    mode_a: dprwm_legal(2'(`DPRWM_CTRL_RST >> `DPRWM_CTRL_MODE_A_LSB)),
    mode_b: dprwm_legal(2'(`DPRWM_CTRL_RST >> `DPRWM_CTRL_MODE_B_LSB)),
    sts:    `DPRWM_STS_RST,
    ack:    1'b0,
    rdat:   32'h0
  };

  dprwm_state_t       st_q;
  dprwm_state_t       st_d;
  logic               en_a;
  logic               en_b;
  logic               a_ok;
  logic               b_ok;
  logic               same;
  logic               wr_a;
  logic               wr_b;
  logic               ww;
  logic               a_bad_wr;
  logic               b_bad_wr;
  dprwm_wmode_t       eff_a;
  dprwm_wmode_t       eff_b;
  logic [WIDTH_A-1:0] rd_a_word;
  logic [WIDTH_B-1:0] rd_b_word;
  logic               wb_req;
  logic [2:0]         sts_set;
  logic [2:0]         sts_clr;

  assign en_a = !HAS_EN_A || A_EN;
  assign en_b = !HAS_EN_B || B_EN;
  assign a_ok = int'(A_ADDR) < DEPTH_A;
  assign b_ok = int'(B_ADDR) < DEPTH_B;
  // Port B cell covers FF port A words
  assign same = a_ok && b_ok && ((int'(A_ADDR) / FF) == int'(B_ADDR));
  assign eff_a = dprwm_eff(st_q.mode_a);
  assign eff_b = dprwm_eff(st_q.mode_b);
  assign wr_a = en_a && A_WE && a_ok;
  // port B is read-only when distributed
  assign wr_b = en_b && B_WE && b_ok && (MEM_KIND != DPRWM_DIST);
  assign ww = wr_a && wr_b && same;
  // reader is spoiled unless writer reads first
  assign a_bad_wr = en_a && !wr_a && wr_b && same && (eff_b != DPRWM_RBW);
  assign b_bad_wr = en_b && !wr_b && wr_a && same && (eff_a != DPRWM_RBW);
  // plain reads of the stored contents
  assign rd_a_word = a_ok ? st_q.mem[A_ADDR] : '0;
  assign rd_b_word = b_ok ? dprwm_rd_b(st_q.mem, B_ADDR) : '0;
  assign wb_req = WB_CYC && WB_STB && !st_q.ack;
  assign sts_set = {(en_a && !a_ok) || (en_b && !b_ok), a_bad_wr || b_bad_wr, ww};
  assign sts_clr = (wb_req && WB_WE && WB_SEL[0] && WB_ADR == `DPRWM_OFS_STATUS)
                   ? WB_DAT_I[2:0] : 3'h0;

  always_comb begin
    st_d = st_q;
    // a concurrent read never blocks the store
    if (wr_a) begin
      st_d.mem[A_ADDR] = A_WDATA;
    end
    // Same-cell double write leaves port B's data; outputs are flagged anyway
    if (wr_b) begin
      for (int k = 0; k < FF; k++) begin
        st_d.mem[int'(B_ADDR) * FF + k] = B_WDATA[k*WIDTH_A +: WIDTH_A];
      end
    end
    // one-cycle registered read on port A
    if (en_a) begin
      st_d.inva = ww || a_bad_wr;
      if (wr_a) begin
        unique case (eff_a)
          DPRWM_RAW: st_d.qa = A_WDATA;
          DPRWM_RBW: st_d.qa = rd_a_word;
          DPRWM_NRW: st_d.qa = st_q.qa;
        endcase
      end else begin
        // old contents beside a read-first writer
        st_d.qa = rd_a_word;
      end
    end
    // one-cycle registered read on port B
    if (en_b) begin
      st_d.invb = ww || b_bad_wr;
      if (wr_b) begin
        unique case (eff_b)
          DPRWM_RAW: st_d.qb = B_WDATA;
          DPRWM_RBW: st_d.qb = rd_b_word;
          DPRWM_NRW: st_d.qb = st_q.qb;
        endcase
      end else begin
        st_d.qb = rd_b_word;
      end
    end
    if (HAS_RST_A && A_RST) begin
      st_d.qa = OUT_A_INIT[WIDTH_A-1:0];
      st_d.inva = 1'b0;
    end
    if (HAS_RST_B && B_RST) begin
      st_d.qb = OUT_B_INIT[WIDTH_B-1:0];
      st_d.invb = 1'b0;
    end
    // Sticky events; a new event outranks a clear in the same cycle
    st_d.sts = (st_q.sts & ~sts_clr) | sts_set;
    // Classic Wishbone: ack one cycle after the strobe, low the next
    st_d.ack = wb_req;
    if (wb_req) begin
      unique case (WB_ADR)
        `DPRWM_OFS_CTRL: st_d.rdat = {28'h0, st_q.mode_b, st_q.mode_a};
        `DPRWM_OFS_STATUS: st_d.rdat = {29'h0, st_q.sts};
        `DPRWM_OFS_INFO: st_d.rdat = 32'(DEPTH_A);
        default: st_d.rdat = 32'h0;
      endcase
      // both ports' modes are set by the same write, each from its own field
      if (WB_WE && WB_SEL[0] && WB_ADR == `DPRWM_OFS_CTRL) begin
        st_d.mode_a = dprwm_legal(WB_DAT_I[`DPRWM_CTRL_MODE_A_LSB +: 2]);
        st_d.mode_b = dprwm_legal(WB_DAT_I[`DPRWM_CTRL_MODE_B_LSB +: 2]);
      end
    end
  end

  // device reset reloads contents and outputs
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_q <= RST_STATE;
    end else begin
      st_q <= st_d;
    end
  end

  // invalid flags ride with the data
  assign A_RDATA   = st_q.qa;
  assign A_INVALID = st_q.inva;
  assign B_RDATA   = st_q.qb;
  assign B_INVALID = st_q.invb;
  assign WB_DAT_O  = st_q.rdat;
  assign WB_ACK    = st_q.ack;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  property p_idle_read;
    en_a && !A_WE && !(HAS_RST_A && A_RST) && !a_bad_wr |=> A_RDATA == $past(rd_a_word);
  endproperty
  a_idle_read: assert property (p_idle_read) else $error("Idle read wrong");

  property p_store;
    wr_a && !(wr_b && same) |=> st_q.mem[$past(A_ADDR)] == $past(A_WDATA);
  endproperty
  a_store: assert property (p_store) else $error("Write not stored");

  property p_nrw_hold;
    wr_a && eff_a == DPRWM_NRW && !(HAS_RST_A && A_RST) |=> $stable(A_RDATA);
  endproperty
  a_nrw_hold: assert property (p_nrw_hold) else $error("Output moved on write");

  property p_raw;
    wr_a && eff_a == DPRWM_RAW && !(HAS_RST_A && A_RST) |=> A_RDATA == $past(A_WDATA);
  endproperty
  a_raw: assert property (p_raw) else $error("Read after write wrong");

  property p_rbw;
    wr_b && eff_b == DPRWM_RBW && !(HAS_RST_B && B_RST) |=> B_RDATA == $past(rd_b_word);
  endproperty
  a_rbw: assert property (p_rbw) else $error("Read before write wrong");

  property p_ww;
    ww && !(HAS_RST_A && A_RST) && !(HAS_RST_B && B_RST) |=> A_INVALID && B_INVALID;
  endproperty
  a_ww: assert property (p_ww) else $error("Write collision not flagged");

  property p_wr_old;
    en_a && !A_WE && wr_b && same && eff_b == DPRWM_RBW && !(HAS_RST_A && A_RST)
      |=> !A_INVALID && A_RDATA == $past(rd_a_word);
  endproperty
  a_wr_old: assert property (p_wr_old) else $error("Old data lost");

  property p_wr_bad;
    b_bad_wr && !(HAS_RST_B && B_RST) |=> B_INVALID ##1
      (B_INVALID || $past(en_b) || $past(HAS_RST_B && B_RST));
  endproperty
  a_wr_bad: assert property (p_wr_bad) else $error("Collision not flagged");

  property p_dist_ro;
    MEM_KIND == DPRWM_DIST && en_b && B_WE && !wr_a |=> $stable(st_q.mem);
  endproperty
  a_dist_ro: assert property (p_dist_ro) else $error("Port B wrote memory");

  property p_out_rst;
    HAS_RST_A && A_RST |=> A_RDATA == OUT_A_INIT[WIDTH_A-1:0] && !A_INVALID;
  endproperty
  a_out_rst: assert property (p_out_rst) else $error("Output reset wrong");

  property p_wb_ack;
    wb_req |=> WB_ACK ##1 !WB_ACK;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("Bus ack timing wrong");

  c_rbw_collision: cover property (en_a && !A_WE && wr_b && same && eff_b == DPRWM_RBW);
  c_ww_collision: cover property (ww);
  c_nrw_write: cover property (wr_a && eff_a == DPRWM_NRW);
  c_wb_write: cover property (wb_req && WB_WE);

endmodule

// file: dprwm_user.sv
// Behavioural user logic on the far side of RAM port B
`timescale 1ns/100ps

module dprwm_user (
  input  wire logic        clk,
  output logic             b_en,
  output logic             b_rst,
  output logic [2:0]       b_addr,
  output logic             b_we,
  output logic [15:0]      b_wdata
);

  initial begin
    b_en = 1'b0;
    b_rst = 1'b0;
    b_addr = 3'h0;
    b_we = 1'b0;
    b_wdata = 16'h0000;
  end

  // One access; released address and data lines show the inverse so stale values never pass
  // address below depth
  task automatic b_op(input logic we, input logic [2:0] addr, input logic [15:0] wdata);
    @(posedge clk);
    b_en <= 1'b1;
    b_we <= we;
    b_addr <= addr;
    b_wdata <= wdata;
    @(posedge clk);
    b_en <= 1'b0;
    b_we <= 1'b0;
    b_addr <= ~addr;
    b_wdata <= ~wdata;
  endtask

  task automatic b_reset();
    @(posedge clk);
    b_rst <= 1'b1;
    @(posedge clk);
    b_rst <= 1'b0;
  endtask

endmodule

// file: dprwm_ram_test.sv
// Self-checking bench for the dual-port RAM with write modes
`timescale 1ns/100ps

module dprwm_ram_test;
  import dprwm_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        a_en = 1'b0;
  logic        a_rst = 1'b0;
  logic [3:0]  a_addr = 4'h0;
  logic        a_we = 1'b0;
  logic [7:0]  a_wdata = 8'h00;
  logic [7:0]  a_rdata;
  logic        a_inv;
  logic        b_en, b_rst, b_we, b_inv;
  logic [2:0]  b_addr;
  logic [15:0] b_wdata, b_rdata;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [3:0]  wb_sel = 4'hf;
  logic [3:0]  wb_adr = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack;
  logic [7:0]  mem_ref [16];
  logic [7:0]  old;
  logic [7:0]  exp8;
  logic [15:0] last_b;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  dprwm_wmode_t modes [3] = '{DPRWM_RAW, DPRWM_RBW, DPRWM_NRW};

  always #2 clk = ~clk;

  dprwm_ram #(.INIT_LEN(2),
    .INIT_VEC({32'h0000_01ff, 32'h0000_005a}), .INIT_OUT_A(300), .INIT_OUT_B(7)) DUT (
    .SYS_CLK(clk), .SYS_RST(rst), .A_EN(a_en), .A_RST(a_rst), .A_ADDR(a_addr),
    .A_WE(a_we), .A_WDATA(a_wdata), .A_RDATA(a_rdata), .A_INVALID(a_inv),
    .B_EN(b_en), .B_RST(b_rst), .B_ADDR(b_addr), .B_WE(b_we), .B_WDATA(b_wdata),
    .B_RDATA(b_rdata), .B_INVALID(b_inv), .WB_CYC(wb_cyc), .WB_STB(wb_stb),
    .WB_WE(wb_we), .WB_ADR(wb_adr), .WB_SEL(wb_sel), .WB_DAT_I(wb_dat_i),
    .WB_DAT_O(wb_dat_o), .WB_ACK(wb_ack));

  dprwm_user u_user (.clk(clk), .b_en(b_en), .b_rst(b_rst), .b_addr(b_addr), .b_we(b_we),
    .b_wdata(b_wdata));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Test should take under two hundred cycles; the ceiling leaves ample room
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] wdat,
                          output logic [31:0] rdat);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_i <= wdat;
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    rdat = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wb_wr(input logic [3:0] adr, input logic [31:0] dat);
    logic [31:0] r;
    wb_cycle(1'b1, adr, dat, r);
  endtask

  task automatic wb_chk(input logic [3:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    wb_cycle(1'b0, adr, 32'h0, r);
    check("register", r, exp);
  endtask

  // Port A access; outputs are looked at once the edge's updates have landed
  task automatic a_op(input logic en, input logic we, input logic [3:0] ad, input logic [7:0] wd);
    @(posedge clk);
    a_en <= en;
    a_we <= we;
    a_addr <= ad;
    a_wdata <= wd;
    @(posedge clk);
    a_en <= 1'b0;
    a_we <= 1'b0;
    a_addr <= ~ad;
    a_wdata <= ~wd;
    #1;
  endtask

  task automatic both(input logic awe, input logic [3:0] aad, input logic [7:0] awd,
                      input logic bwe, input logic [2:0] bad, input logic [15:0] bwd);
    fork
      a_op(1'b1, awe, aad, awd);
      u_user.b_op(bwe, bad, bwd);
    join
  endtask

  task automatic a_rd(input logic [3:0] ad);
    a_op(1'b1, 1'b0, ad, 8'h00);
    check("a_rdata", 32'(a_rdata), 32'(mem_ref[ad]));
  endtask

  initial begin
    foreach (mem_ref[i]) mem_ref[i] = 8'h00;
    mem_ref[0] = 8'h5a;
    mem_ref[1] = 8'hff;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("a_init", 32'(a_rdata), 32'h0000_00ff);
    check("b_init", 32'(b_rdata), 32'h0000_0007);
    wb_chk(4'h0, 32'h0);
    wb_chk(4'h4, 32'h0);
    wb_chk(4'hc, 32'h0);
    wb_wr(4'h8, 32'h0);
    wb_chk(4'h8, 32'd16);
    wb_sel <= 4'he;
    wb_wr(4'h0, 32'h5);
    wb_sel <= 4'hf;
    wb_chk(4'h0, 32'h0);
    wb_wr(4'h0, 32'h3);
    wb_chk(4'h0, 32'h0);
    $display("test registers done");
    a_rd(4'h0);
    a_rd(4'h1);
    a_rd(4'h5);
    u_user.b_op(1'b0, 3'h0, 16'h0);
    #1;
    check("b_rdata", 32'(b_rdata), 32'h0000_ff5a);
    $display("test init done");
    foreach (modes[m]) begin
      wb_wr(4'h0, 32'(modes[m]));
      wb_chk(4'h0, 32'(modes[m]));
      a_rd(4'h3);
      old = mem_ref[2];
      a_op(1'b1, 1'b1, 4'h2, 8'h10 + 8'(m));
      mem_ref[2] = 8'h10 + 8'(m);
      exp8 = (m == 0) ? mem_ref[2] : (m == 1) ? old : mem_ref[3];
      check("a_wmode", 32'(a_rdata), 32'(exp8));
      a_rd(4'h2);
    end
    $display("test write modes done");
    a_op(1'b1, 1'b1, 4'h4, 8'h44);
    mem_ref[4] = 8'h44;
    both(1'b0, 4'h4, 8'h00, 1'b0, 3'h2, 16'h0);
    check("rr_inv", {30'h0, a_inv, b_inv}, 32'h0);
    check("rr_a", 32'(a_rdata), 32'(mem_ref[4]));
    check("rr_b", 32'(b_rdata), 32'({mem_ref[5], mem_ref[4]}));
    wb_wr(4'h0, 32'(DPRWM_RBW));
    both(1'b1, 4'h6, 8'hc3, 1'b0, 3'h3, 16'h0);
    check("wr_b", {15'h0, b_inv, b_rdata}, 32'({mem_ref[7], mem_ref[6]}));
    mem_ref[6] = 8'hc3;
    a_rd(4'h6);
    wb_wr(4'h0, 32'(DPRWM_RAW));
    // Reader data is not compared while flagged invalid
    // skipped data
    both(1'b1, 4'h6, 8'h3c, 1'b0, 3'h3, 16'h0);
    check("wr_inv", 32'(b_inv), 32'h1);
    mem_ref[6] = 8'h3c;
    wb_chk(4'h4, 32'h2);
    wb_wr(4'h4, 32'h7);
    both(1'b1, 4'h8, 8'h11, 1'b1, 3'h4, 16'hbeef);
    check("ww_inv", {30'h0, a_inv, b_inv}, 32'h3);
    mem_ref[8] = 8'hef;
    mem_ref[9] = 8'hbe;
    wb_chk(4'h4, 32'h1);
    wb_wr(4'h4, 32'h7);
    wb_chk(4'h4, 32'h0);
    a_rd(4'h9);
    $display("test collisions done");
    a_op(1'b0, 1'b1, 4'h5, 8'h77);
    check("a_hold", 32'(a_rdata), 32'(mem_ref[9]));
    a_rd(4'h5);
    @(posedge clk);
    a_rst <= 1'b1;
    @(posedge clk);
    a_rst <= 1'b0;
    #1;
    check("a_rst", 32'(a_rdata), 32'h0000_00ff);
    wb_wr(4'h0, 32'({DPRWM_NRW, 2'b00}));
    u_user.b_op(1'b0, 3'h0, 16'h0);
    #1;
    last_b = {mem_ref[1], mem_ref[0]};
    u_user.b_op(1'b1, 3'h1, 16'h5678);
    #1;
    check("b_nrw", 32'(b_rdata), 32'(last_b));
    mem_ref[2] = 8'h78;
    mem_ref[3] = 8'h56;
    a_rd(4'h3);
    wb_wr(4'h0, 32'({DPRWM_RBW, 2'b00}));
    both(1'b0, 4'h2, 8'h00, 1'b1, 3'h1, 16'h9abc);
    check("ra_old", {23'h0, a_inv, a_rdata}, 32'(mem_ref[2]));
    check("b_rbw", 32'(b_rdata), 32'({mem_ref[3], mem_ref[2]}));
    mem_ref[2] = 8'hbc;
    mem_ref[3] = 8'h9a;
    a_rd(4'h2);
    u_user.b_reset();
    #1;
    check("b_rst", {15'h0, b_inv, b_rdata}, 32'h0000_0007);
    $display("test port controls done");
    give_verdict();
  end

endmodule
